// >>> fpms_button.v
// Pushbutton conditioner: three-stage synchroniser, debounce, press pulse.
// Assumes the button is a raw pin, high while pressed.
`timescale 1ns/1ps

module fpms_button
#(
  parameter DEB_CYC = 2000000
)
(
  clk,
  rst_n,
  clk_en,
  button_raw,
  press_pulse
);
  input        clk;
  input        rst_n;
  input        clk_en;
  input        button_raw;
  output       press_pulse;

  reg          sync1_ff;
  reg          sync2_ff;
  reg          sync3_ff;
  reg          stable_ff;
  reg  [31:0]  deb_cnt_ff;
  reg          press_ff;

  // ========================================================================
  // Synchroniser; a change counts once stages two and three agree
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_ff <= button_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // ========================================================================
  // Debounce: level must hold for DEB_CYC before it is accepted
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stable_ff  <= 1'b0;
      deb_cnt_ff <= 32'h0000_0000;
      press_ff   <= 1'b0;
    end
    else if (clk_en)
    begin
      press_ff <= 1'b0;
      if ((sync2_ff != sync3_ff) || (sync3_ff == stable_ff))
        deb_cnt_ff <= 32'h0000_0000;
      else if (deb_cnt_ff >= DEB_CYC - 1)
      begin
        deb_cnt_ff <= 32'h0000_0000;
        stable_ff  <= sync3_ff;
        press_ff   <= sync3_ff;
      end
      else
        deb_cnt_ff <= deb_cnt_ff + 32'h0000_0001;
    end
  end

  assign press_pulse = press_ff;

endmodule // fpms_button

// >>> fpms_checker_properties.sv
// Port checker for the front-panel supervisor.
// Assumes clk_en held high; attached by the bind below.
`timescale 1ns/1ps
`include "fpms_defs.vh"

module fpms_checker
(
  input wire       clk,
  input wire       rst_n,
  input wire       reg_rd,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire       halt_jumper,
  input wire [7:0] lamp_a,
  input wire       status_red,
  input wire       status_green,
  input wire       cfg_lock,
  input wire       links_off,
  input wire       handover,
  input wire       unit_reset
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  unit_pulse_a: assert property (unit_reset |=> !unit_reset)
    else $error("Reset pulse lasts more than one cycle");
  summary_type_a: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata == `FPMS_MODULE_TYPE)
    else $error("Summary type byte wrong");
  summary_rev_a: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata == `FPMS_FW_REV)
    else $error("Summary revision byte wrong");
  lock_links_a: assert property (cfg_lock |-> links_off)
    else $error("Links active while stopped");
  handover_lock_a: assert property (handover |-> cfg_lock)
    else $error("Handover outside a stop");
  halt_lamps_a: assert property (cfg_lock |-> lamp_a == 8'h3F)
    else $error("Stopped lamp pattern wrong");
  stop_red_a: assert property ($rose(cfg_lock) && !halt_jumper |-> ##[0:2] (status_red && !status_green))
    else $error("Stop without red status");
  colour_excl_a: assert property (!(status_red && status_green))
    else $error("Status red and green together");
  jumper_dark_a: assert property (halt_jumper [*6] |-> !status_red && !status_green)
    else $error("Status lit with jumper fitted");
  reset_init_a: assert property (unit_reset |-> ##[0:2] (lamp_a == 8'hFF && !status_red && !status_green))
    else $error("Reset did not restart the unit");
endmodule // fpms_checker

bind fpms_top fpms_checker u_chk (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .halt_jumper(halt_jumper), .lamp_a(lamp_a), .status_red(status_red),
  .status_green(status_green), .cfg_lock(cfg_lock), .links_off(links_off), .handover(handover),
  .unit_reset(unit_reset));

// >>> fpms_defs.vh
// Constants for the front-panel mode supervisor: register offsets, fields,
// reset values and timing counts. Assumes a 200 MHz module clock.
`ifndef FPMS_DEFS_VH
`define FPMS_DEFS_VH

// ==========================================================================
// Register offsets (word index on the plain register port)
`define FPMS_REG_CTRL      4'h0
`define FPMS_REG_ERRCODE   4'h1
`define FPMS_REG_DIAG      4'h2
`define FPMS_REG_STATUS    4'h3
`define FPMS_REG_SUMMARY   4'h4

// ==========================================================================
// CTRL fields
`define FPMS_CTRL_MODE_LO  0
`define FPMS_CTRL_MODE_HI  1
`define FPMS_CTRL_RDN      2
`define FPMS_CTRL_SEC      3
`define FPMS_CTRL_DIAG     4
`define FPMS_CTRL_NVFLT    5
`define FPMS_CTRL_HWERR    6
`define FPMS_CTRL_ONLINE   7
`define FPMS_CTRL_RST      8'h00

// Operating modes
`define FPMS_MODE_EXEC     2'h0
`define FPMS_MODE_CONF     2'h1
`define FPMS_MODE_ERR      2'h2

// Status indicator colour codes
`define FPMS_COL_OFF       2'h0
`define FPMS_COL_GREEN     2'h1
`define FPMS_COL_RED       2'h2

// Error code shown at startup after a memory fault was flagged
`define FPMS_ERR_NVRAM     8'h01

// Module type and firmware revision, arbitrary neutral values
`define FPMS_MODULE_TYPE   8'h5A
`define FPMS_FW_REV        8'h10

// ==========================================================================
// Timing: a startup step of 100 ms, a blink half period of 500 ms (1 Hz),
// a debounce of 10 ms, a processor init blank of 1 ms
`define FPMS_CLK_MHZ       200
`define FPMS_STEP_MS       100
`define FPMS_BLINK_MS      500
`define FPMS_DEB_MS        10
`define FPMS_INIT_MS       1
`define FPMS_STEP_CYC      (`FPMS_STEP_MS * 1000 * `FPMS_CLK_MHZ)
`define FPMS_BLINK_CYC     (`FPMS_BLINK_MS * 1000 * `FPMS_CLK_MHZ)
`define FPMS_DEB_CYC       (`FPMS_DEB_MS * 1000 * `FPMS_CLK_MHZ)
`define FPMS_INIT_CYC      (`FPMS_INIT_MS * 1000 * `FPMS_CLK_MHZ)

`endif

// >>> fpms_operator.sv
// Operator model: one bouncing pushbutton press held for a set time.
// Assumes a new request only while busy is low.
`timescale 1ns/1ps

module fpms_operator
(
  input  wire       clk,
  input  wire       press_req,
  input  wire [7:0] hold_cyc,
  output logic      button_raw,
  output logic      busy
);
  // ==========================================================================
  // Idle level, then one press with contact bounce on both edges per request;
  // a single process drives both outputs
  initial
  begin
    button_raw = 1'b0;
    busy       = 1'b0;
    forever
    begin
      @(posedge clk);
      if (press_req)
      begin
        busy <= 1'b1;
        repeat (2)
        begin
          button_raw <= 1'b1;
          @(posedge clk);
          button_raw <= 1'b0;
          @(posedge clk);
        end
        button_raw <= 1'b1;
        repeat (hold_cyc) @(posedge clk);
        button_raw <= 1'b0;
        @(posedge clk);
        button_raw <= 1'b1;   // Release bounce
        @(posedge clk);
        button_raw <= 1'b0;
        repeat (8) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule // fpms_operator

// >>> fpms_top.v
// Front-panel mode supervisor: startup lamp sequence, mode display, error
// codes, diagnostic counts and a two-stage stop/reset pushbutton.
// Assumes firmware drives the register port and the lamps are active high.
`timescale 1ns/1ps
`include "fpms_defs.vh"

module fpms_top
#(
  parameter STEP_CYC  = `FPMS_STEP_CYC,
  parameter BLINK_CYC = `FPMS_BLINK_CYC,
  parameter DEB_CYC   = `FPMS_DEB_CYC,
  parameter INIT_CYC  = `FPMS_INIT_CYC
)
(
  clk,
  rst_n,
  clk_en,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  button_raw,
  halt_jumper,
  lamp_a,
  lamp_b,
  status_red,
  status_green,
  cfg_lock,
  links_off,
  handover,
  nv_write_en,
  unit_reset
);
  input         clk;
  input         rst_n;
  input         clk_en;
  input  [3:0]  reg_addr;
  input  [7:0]  reg_wdata;
  input         reg_wr;
  input         reg_rd;
  output [7:0]  reg_rdata;
  input         button_raw;
  input         halt_jumper;
  output [7:0]  lamp_a;
  output [7:0]  lamp_b;
  output        status_red;
  output        status_green;
  output        cfg_lock;
  output        links_off;
  output        handover;
  output        nv_write_en;
  output        unit_reset;

  // States
  localparam ST_INIT  = 3'h0;
  localparam ST_SEQ   = 3'h1;
  localparam ST_RUN   = 3'h2;
  localparam ST_STOP  = 3'h3;
  localparam ST_EHALT = 3'h4;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [2:0]  step_ff;
  reg  [31:0] tmr_ff;
  reg  [31:0] blink_cnt_ff;
  reg         blink_ff;
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  err_code_ff;
  reg  [7:0]  diag_ff;
  reg         nv_pending_ff;
  reg         nv_sticky_ff;
  reg  [7:0]  rdata_ff;
  reg  [7:0]  lamp_a_ff;
  reg  [7:0]  lamp_b_ff;
  reg         red_ff;
  reg         green_ff;
  reg         lock_ff;
  reg         links_off_ff;
  reg         handover_ff;
  reg         nv_we_ff;
  reg         unit_rst_ff;
  reg         jmp1_ff;
  reg         jmp2_ff;
  reg         jmp3_ff;
  reg         jmp_ff;
  reg  [7:0]  nxt_a;
  reg  [7:0]  nxt_b;
  reg  [1:0]  nxt_col;
  reg  [7:0]  summ_byte;

  wire        press;
  wire [1:0]  mode      = ctrl_ff[`FPMS_CTRL_MODE_HI:`FPMS_CTRL_MODE_LO];
  wire        redundant = ctrl_ff[`FPMS_CTRL_RDN];
  wire        secondary = ctrl_ff[`FPMS_CTRL_SEC];
  wire        step_done = (tmr_ff >= STEP_CYC - 1);
  wire        seq_last  = secondary ? (step_ff == 3'h4) : (step_ff == 3'h3);

  // ========================================================================
  // Pushbutton conditioner
  fpms_button
  #(
    .DEB_CYC     (DEB_CYC)
  )
  u_button
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .button_raw  (button_raw),
    .press_pulse (press)
  );

  // ========================================================================
  // Halt jumper synchroniser
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jmp1_ff <= 1'b0;
      jmp2_ff <= 1'b0;
      jmp3_ff <= 1'b0;
      jmp_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      jmp1_ff <= halt_jumper;
      jmp2_ff <= jmp1_ff;
      jmp3_ff <= jmp2_ff;
      if (jmp2_ff == jmp3_ff)
        jmp_ff <= jmp3_ff;
    end
  end

  // ========================================================================
  // Blink divider, toggles every BLINK_CYC for roughly 1 Hz
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt_ff <= 32'h0000_0000;
      blink_ff     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (blink_cnt_ff >= BLINK_CYC - 1)
      begin
        blink_cnt_ff <= 32'h0000_0000;
        blink_ff     <= ~blink_ff;
      end
      else
        blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
    end
  end

  // ========================================================================
  // Supervisor state machine
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_INIT:
        if (tmr_ff >= INIT_CYC - 1)
          nxt_state = nv_sticky_ff ? ST_EHALT : ST_SEQ;
      ST_SEQ:
        if (step_done && seq_last)
          nxt_state = ST_RUN;
      ST_RUN:
        if (ctrl_ff[`FPMS_CTRL_HWERR])
          nxt_state = ST_EHALT;
        else if (press)
          nxt_state = ST_STOP;
      ST_STOP:
        if (press)
          nxt_state = ST_INIT;
      ST_EHALT:
        if (press)
          nxt_state = ST_INIT;
      default:
        nxt_state = ST_INIT;
    endcase
  end

  // Reset request from a press while stopped or error-halted, used by the register and output blocks
  wire do_reset = press && ((state_ff == ST_STOP) || (state_ff == ST_EHALT));

  // ========================================================================
  // State, timer and step counter
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_INIT;
      tmr_ff   <= 32'h0000_0000;
      step_ff  <= 3'h0;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff)
      begin
        tmr_ff  <= 32'h0000_0000;
        step_ff <= 3'h0;
      end
      else if (state_ff == ST_SEQ && step_done)
      begin
        tmr_ff  <= 32'h0000_0000;
        step_ff <= step_ff + 3'h1;
      end
      else
        tmr_ff <= tmr_ff + 32'h0000_0001;
    end
  end

  // ========================================================================
  // Register port: writes, and memory fault sticky flag
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff       <= `FPMS_CTRL_RST;
      err_code_ff   <= 8'h00;
      diag_ff       <= 8'h00;
      nv_pending_ff <= 1'b0;
      nv_sticky_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (do_reset)
      begin
        // Restore power-up defaults; role survives, the memory fault flag only on a reset from ST_STOP
        ctrl_ff     <= `FPMS_CTRL_RST | (ctrl_ff & 8'h0C);
        err_code_ff <= 8'h00;
        diag_ff     <= 8'h00;
      end
      else if (reg_wr && !lock_ff)
      begin
        case (reg_addr)
          `FPMS_REG_CTRL:    ctrl_ff     <= reg_wdata;
          `FPMS_REG_ERRCODE: err_code_ff <= reg_wdata;
          `FPMS_REG_DIAG:    diag_ff     <= reg_wdata;
          `FPMS_REG_STATUS:  nv_pending_ff <= reg_wdata[0];
          default:           nv_pending_ff <= nv_pending_ff;
        endcase
      end
      else if (lock_ff)
        nv_pending_ff <= 1'b0;
      if (ctrl_ff[`FPMS_CTRL_NVFLT])
        nv_sticky_ff <= 1'b1;
      else if (state_ff == ST_EHALT && do_reset)
        nv_sticky_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Status summary record, six bytes at offsets 4..9; offsets 10..15 read zero
  always @*
  begin
    summ_byte = 8'h00;
    case (reg_addr - `FPMS_REG_SUMMARY)
      4'h0:    summ_byte = {5'h00, nv_sticky_ff, ctrl_ff[`FPMS_CTRL_HWERR],
                            state_ff == ST_EHALT};
      4'h1:    summ_byte = err_code_ff;
      4'h2:    summ_byte = `FPMS_MODULE_TYPE;
      4'h3:    summ_byte = `FPMS_FW_REV;
      4'h4:    summ_byte = {5'h00, state_ff};
      4'h5:    summ_byte = diag_ff;
      default: summ_byte = 8'h00;
    endcase
  end

  // Read data, one cycle after the strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (clk_en)
    begin
      if (!reg_rd)
        rdata_ff <= 8'h00;
      else
        case (reg_addr)
          `FPMS_REG_CTRL:    rdata_ff <= ctrl_ff;
          `FPMS_REG_ERRCODE: rdata_ff <= err_code_ff;
          `FPMS_REG_DIAG:    rdata_ff <= diag_ff;
          `FPMS_REG_STATUS:  rdata_ff <= {3'h0, nv_sticky_ff, lock_ff, state_ff};
          default:           rdata_ff <= summ_byte;
        endcase
    end
  end

  // ========================================================================
  // Lamp pattern and status colour
  always @*
  begin
    nxt_a   = 8'h00;
    nxt_b   = 8'h00;
    nxt_col = `FPMS_COL_OFF;
    case (state_ff)
      ST_INIT:
      begin
        nxt_a   = 8'hFF;
        nxt_b   = 8'hFF;
        nxt_col = `FPMS_COL_OFF;
      end
      ST_SEQ:
      begin
        nxt_col = (step_ff == 3'h0) ? `FPMS_COL_RED : `FPMS_COL_GREEN;
        if (!secondary)
          case (step_ff)
            3'h0, 3'h1: begin nxt_a = 8'hFF; nxt_b = 8'hFF; end
            3'h2:       begin nxt_a = 8'hC0; nxt_b = 8'hFF; end
            default:    begin nxt_a = 8'hC0; nxt_b = 8'h00; end
          endcase
        else
          case (step_ff)
            3'h0, 3'h1: begin nxt_a = 8'hFF; nxt_b = 8'hFF; end
            3'h2:       nxt_a = 8'h00;
            3'h3:       nxt_a = 8'h40;
            default:    nxt_a = 8'h80;
          endcase
      end
      ST_RUN:
      begin
        if (!ctrl_ff[`FPMS_CTRL_ONLINE])
        begin
          nxt_a = 8'hFF;
          nxt_b = 8'hFF;
        end
        else
        begin
          if (mode == `FPMS_MODE_ERR)
            nxt_a = err_code_ff;
          else if (redundant)
            nxt_a = secondary ? 8'h80 : 8'hC0;
          if (ctrl_ff[`FPMS_CTRL_DIAG])
            nxt_b = diag_ff;
        end
        if (mode == `FPMS_MODE_EXEC && !ctrl_ff[`FPMS_CTRL_NVFLT])
          nxt_col = `FPMS_COL_GREEN;
        else
          nxt_col = blink_ff ? `FPMS_COL_GREEN : `FPMS_COL_OFF;
      end
      ST_STOP:
      begin
        nxt_a   = 8'h3F;
        nxt_col = `FPMS_COL_RED;
      end
      ST_EHALT:
      begin
        nxt_a   = nv_sticky_ff ? `FPMS_ERR_NVRAM : err_code_ff;
        nxt_col = `FPMS_COL_RED;
      end
      default:
        nxt_col = `FPMS_COL_OFF;
    endcase
    if (jmp_ff)
      nxt_col = `FPMS_COL_OFF;
  end

  // ========================================================================
  // Registered outputs, eighteen indicators and stop actions
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lamp_a_ff    <= 8'h00;
      lamp_b_ff    <= 8'h00;
      red_ff       <= 1'b0;
      green_ff     <= 1'b0;
      lock_ff      <= 1'b0;
      links_off_ff <= 1'b1;
      handover_ff  <= 1'b0;
      nv_we_ff     <= 1'b0;
      unit_rst_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      lamp_a_ff    <= nxt_a;
      lamp_b_ff    <= nxt_b;
      red_ff       <= (nxt_col == `FPMS_COL_RED);
      green_ff     <= (nxt_col == `FPMS_COL_GREEN);
      lock_ff      <= (state_ff == ST_STOP);
      links_off_ff <= (state_ff != ST_RUN);
      handover_ff  <= (state_ff == ST_STOP) && redundant;
      nv_we_ff     <= (state_ff == ST_RUN && mode == `FPMS_MODE_CONF)
                      || nv_pending_ff;
      unit_rst_ff  <= do_reset;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign lamp_a       = lamp_a_ff;
  assign lamp_b       = lamp_b_ff;
  assign status_red   = red_ff;
  assign status_green = green_ff;
  assign cfg_lock     = lock_ff;
  assign links_off    = links_off_ff;
  assign handover     = handover_ff;
  assign nv_write_en  = nv_we_ff;
  assign unit_reset   = unit_rst_ff;

endmodule // fpms_top

// >>> fpms_top_bench.sv
// Self-checking bench for the front-panel supervisor.
// Assumes short timing parameters and the operator model beside it.
`timescale 1ns/1ps
`include "fpms_defs.vh"

module fpms_top_bench;
  logic        clk;
  logic        rst_n;
  logic        clk_en;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        press_req;
  logic [7:0]  hold_cyc;
  logic        halt_jumper;
  wire  [7:0]  reg_rdata;
  wire  [7:0]  lamp_a;
  wire  [7:0]  lamp_b;
  wire         button_raw;
  wire         busy;
  wire         status_red;
  wire         status_green;
  wire         cfg_lock;
  wire         links_off;
  wire         handover;
  wire         nv_write_en;
  wire         unit_reset;
  int          n_fail;
  int          cmp_count;
  int          n_rst;
  logic [7:0]  ctrl_m;
  logic [7:0]  diag_m;
  logic [7:0]  err_m;
  logic        lock_m;
  logic [18:0] seq_q[$];
  logic [7:0]  d;
  logic [7:0]  e;

  // ==========================================================================
  // Clock, design and operator
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  fpms_top #(.STEP_CYC(8), .BLINK_CYC(4), .DEB_CYC(3), .INIT_CYC(4)) u_dut (.clk(clk),
    .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .button_raw(button_raw), .halt_jumper(halt_jumper),
    .lamp_a(lamp_a), .lamp_b(lamp_b), .status_red(status_red), .status_green(status_green),
    .cfg_lock(cfg_lock), .links_off(links_off), .handover(handover), .nv_write_en(nv_write_en),
    .unit_reset(unit_reset));

  fpms_operator u_op (.clk(clk), .press_req(press_req), .hold_cyc(hold_cyc),
    .button_raw(button_raw), .busy(busy));

  // Count accepted reset presses
  always @(posedge clk)
  begin
    if (unit_reset === 1'b1)
      n_rst++;
  end

  // ==========================================================================
  // Tasks
  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (!lock_m && a == `FPMS_REG_CTRL) ctrl_m = v;
    if (!lock_m && a == `FPMS_REG_ERRCODE) err_m = v;
    if (!lock_m && a == `FPMS_REG_DIAG) diag_m = v;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
  endtask

  // Wait for a lamp pattern; es[2] set means status is not looked at
  task automatic chk(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] mb,
                     input logic [2:0] es, input int lim);
    int i;
    logic ok;
    ok = 1'b0;
    for (i = 0; i < lim && !ok; i++)
    begin
      @(posedge clk);
      #1;
      ok = (lamp_a === ea) && ((lamp_b & mb) === (eb & mb)) &&
           (es[2] || ({status_red, status_green} === es[1:0]));
    end
    cmp_count++;
    if (!ok)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, {lamp_a, lamp_b, status_red, status_green},
               {ea, eb, es[1:0]});
    end
  endtask

  // Expected startup steps, ending in the not-online run display
  task automatic build_seq(input logic sec);
    seq_q.push_back({8'hFF, 8'hFF, 3'b000});
    seq_q.push_back({8'hFF, 8'hFF, 3'b010});
    seq_q.push_back({8'hFF, 8'hFF, 3'b001});
    if (sec)
    begin
      seq_q.push_back({8'h00, 8'h00, 3'b100});
      seq_q.push_back({8'h40, 8'h00, 3'b100});
      seq_q.push_back({8'h80, 8'h00, 3'b100});
    end
    else
    begin
      seq_q.push_back({8'hC0, 8'hFF, 3'b001});
      seq_q.push_back({8'hC0, 8'h00, 3'b001});
    end
    seq_q.push_back({8'hFF, 8'hFF, 3'b001});
    while (seq_q.size() > 0)
    begin
      d = seq_q[0][10:3];
      chk(seq_q[0][18:11], d, 8'hFF, seq_q[0][2:0], 20);
      void'(seq_q.pop_front());
    end
  endtask

  // Green seen both on and off over a window means blinking
  task automatic blink(input logic exp);
    int i;
    logic [1:0] seen;
    seen = 2'b00;
    repeat (4) @(posedge clk);
    for (i = 0; i < 24; i++)
    begin
      @(posedge clk);
      #1;
      if (status_green === 1'b1) seen[0] = 1'b1;
      else seen[1] = 1'b1;
    end
    cmp({6'h0, seen}, exp ? 8'h03 : 8'h01);
  endtask

  // One press; a press while stopped or halted resets the model
  task automatic press(input logic [7:0] hold, input logic halted);
    int i;
    for (i = 0; i < 300 && busy; i++) @(posedge clk);
    @(posedge clk);
    press_req <= 1'b1;
    hold_cyc  <= hold;
    @(posedge clk);
    press_req <= 1'b0;
    if (lock_m || halted)
    begin
      lock_m = 1'b0;
      ctrl_m = ctrl_m & 8'h0C;
      diag_m = 8'h00;
      err_m  = 8'h00;
    end
    else
      lock_m = 1'b1;
  endtask

  // ==========================================================================
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0; clk_en = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0;
    reg_rd = 1'b0; press_req = 1'b0; hold_cyc = 8'h00; halt_jumper = 1'b0;
    n_fail = 0; cmp_count = 0; n_rst = 0; lock_m = 1'b0;
    ctrl_m = `FPMS_CTRL_RST; diag_m = 8'h00; err_m = 8'h00;
    void'($urandom(93254));
    repeat (8) @(posedge clk);
    #1;
    cmp(lamp_a, 8'h00);
    cmp({5'h0, status_red, status_green, links_off}, 8'h01);
    @(posedge clk);
    rst_n <= 1'b1;
    build_seq(1'b0);
    wr(`FPMS_REG_CTRL, 8'h84);
    chk(8'hC0, 8'h00, 8'h00, 3'b001, 10);
    d = $urandom;
    wr(`FPMS_REG_DIAG, d);
    wr(`FPMS_REG_CTRL, 8'h94);
    chk(8'hC0, d, 8'hFF, 3'b001, 10);
    rd(`FPMS_REG_CTRL, ctrl_m);
    rd(`FPMS_REG_DIAG, diag_m);
    wr(`FPMS_REG_CTRL, 8'h9C);
    chk(8'h80, 8'h00, 8'h00, 3'b001, 10);
    for (int m = 0; m < 3; m++)
    begin
      wr(`FPMS_REG_CTRL, {6'b100111, m[1:0]});
      blink(m != 0);
      cmp({7'h0, nv_write_en}, {7'h0, m == 1});
    end
    wr(`FPMS_REG_CTRL, 8'h9C);
    // Flag a pending memory write; the stop must finish it
    wr(`FPMS_REG_STATUS, 8'h01);
    @(posedge clk);
    #1;
    cmp({7'h0, nv_write_en}, 8'h01);
    press(8'd40, 1'b0);
    chk(8'h3F, 8'h00, 8'h00, 3'b010, 30);
    cmp({5'h0, cfg_lock, links_off, handover}, 8'h07);
    wr(`FPMS_REG_CTRL, 8'h00);
    rd(`FPMS_REG_CTRL, ctrl_m);
    cmp({7'h0, nv_write_en}, 8'h00);
    press(8'd8, 1'b0);
    cmp(n_rst[7:0], 8'h00);
    build_seq(1'b1);
    cmp(n_rst[7:0], 8'h01);
    rd(`FPMS_REG_CTRL, ctrl_m);
    rd(`FPMS_REG_DIAG, diag_m);
    rd(`FPMS_REG_ERRCODE, err_m);
    e = $urandom;
    e[7] = 1'b1;
    wr(`FPMS_REG_ERRCODE, e);
    wr(`FPMS_REG_CTRL, 8'hCC);
    chk(e, 8'h00, 8'h00, 3'b010, 20);
    press(8'd8, 1'b1);
    chk(8'hFF, 8'hFF, 8'hFF, 3'b000, 30);
    // Last startup step, then the run display, before the fault is set
    chk(8'h80, 8'h00, 8'hFF, 3'b001, 80);
    chk(8'hFF, 8'hFF, 8'hFF, 3'b001, 80);
    wr(`FPMS_REG_CTRL, 8'hAC);
    blink(1'b1);
    chk(8'h80, 8'h00, 8'h00, 3'b100, 5);
    rd(`FPMS_REG_STATUS, 8'h12);
    rd(4'h6, `FPMS_MODULE_TYPE);
    rd(4'h7, `FPMS_FW_REV);
    rd(4'h8, 8'h02);
    wr(4'hF, 8'h55);
    rd(4'hF, 8'h00);
    press(8'd8, 1'b0);
    chk(8'h3F, 8'h00, 8'h00, 3'b010, 30);
    press(8'd8, 1'b0);
    chk(8'hFF, 8'hFF, 8'hFF, 3'b000, 30);
    chk(`FPMS_ERR_NVRAM, 8'h00, 8'h00, 3'b010, 30);
    press(8'd8, 1'b1);
    chk(8'hFF, 8'hFF, 8'hFF, 3'b001, 80);
    @(posedge clk);
    halt_jumper <= 1'b1;
    chk(8'hFF, 8'hFF, 8'hFF, 3'b000, 10);
    tally_and_finish();
  end
endmodule // fpms_top_bench
